// ---- src/scs_pkg.sv ----
// Register map, field layout and carrier types for the SPI channel block
package scs_pkg;

  // Register offsets, one 16-bit register per address
  localparam logic [15:0] OFS_CH1_CTRL = 16'h3548;
  localparam logic [15:0] OFS_CH1_TXL  = 16'h354C;
  localparam logic [15:0] OFS_CH1_TXH  = 16'h354D;
  localparam logic [15:0] OFS_CH1_RXL  = 16'h3550;
  localparam logic [15:0] OFS_CH1_RXH  = 16'h3551;
  localparam logic [15:0] OFS_CH2_CFGL = 16'h3554;
  localparam logic [15:0] OFS_CH2_CFGH = 16'h3555;
  localparam logic [15:0] OFS_CH2_STAT = 16'h3558;

  // Reset values
  localparam logic [15:0] RST_CFGL = 16'h0000;
  localparam logic [15:0] RST_CFGH = 16'h0006;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0]  RST_EXT  = 8'h00;

  // Writable bits of the upper configuration register
  localparam logic [15:0] CFGH_WMASK = 16'h3FFF;

  // Control register fields
  localparam int F_EXT_LSB = 8;
  localparam int B_EN      = 0;

  // Lower configuration fields
  localparam int B_DMA_RX   = 15;
  localparam int B_DMA_TX   = 14;
  localparam int F_DIR_LSB  = 12;
  localparam int F_WL_LSB   = 7;
  localparam int B_SEL_POL  = 6;
  localparam int F_CLOCK_DIVIDER_CODE_LSB = 2;
  localparam int B_IDLE_LVL = 1;
  localparam int B_SAMPLE   = 0;

  // Upper configuration fields
  localparam int B_STEP     = 13;
  localparam int B_RXBUF    = 12;
  localparam int B_TXBUF    = 11;
  localparam int F_TCS_LSB  = 9;
  localparam int B_SB_LVL   = 8;
  localparam int B_SB_ON    = 7;
  localparam int F_SSD_LSB  = 5;
  localparam int B_FORCE    = 4;
  localparam int B_TURBO    = 3;
  localparam int B_IN_SEL   = 2;
  localparam int B_L1_OFF   = 1;
  localparam int B_L0_OFF   = 0;

  // Direction codes
  localparam logic [1:0] DIR_TXRX = 2'h0;
  localparam logic [1:0] DIR_RX   = 2'h1;
  localparam logic [1:0] DIR_TX   = 2'h2;

  // Divider and word-length arithmetic
  localparam logic [15:0] DIV_ONE   = 16'h0001;
  localparam logic [4:0]  WL_TOP    = 5'h1F;
  localparam logic [31:0] WORD_ONES = 32'hFFFFFFFF;

  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_SHIFT, ST_DONE} scs_phase_t;

  // Register port request
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } scs_bus_req_t;

  // Serial pins toward the peripheral
  typedef struct packed {
    logic sclk;
    logic sel;
    logic d0_o;
    logic d0_oe;
    logic d1_o;
    logic d1_oe;
  } scs_pins_t;

  // One word with its valid strobe
  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } scs_word_t;

  // Shared buffer level flags
  typedef struct packed {
    logic rx_full;
    logic rx_empty;
    logic tx_full;
    logic tx_empty;
  } scs_buf_stat_t;

endpackage

// ---- src/scs_clk_div.sv ----
// Serial clock edge tick generator with two divider granularities
`timescale 1ns/1ps
`default_nettype none
module scs_clk_div
  import scs_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Divider setting
  input  wire logic       run,
  input  wire logic       step_one,
  input  wire logic [3:0] code,
  input  wire logic [7:0] ext,
  // One-cycle pulse per serial clock edge
  output logic            tick
);

  typedef struct packed {
    logic [15:0] cnt;
  } scs_div_state_t;

  scs_div_state_t s_q;
  scs_div_state_t s_d;
  logic [15:0]    ratio;

  // Ratio in functional clocks between serial edges
  always_comb begin
    if (step_one) begin
      ratio = 16'({12'h000, code}) + DIV_ONE + 16'({4'h0, ext, 4'h0});
    end else begin
      ratio = DIV_ONE << code;
    end
    tick = run && (s_q.cnt == ratio - DIV_ONE);
  end

  // Counter restarts whenever the engine is idle so the first edge is a full ratio away
  always_comb begin
    s_d = s_q;
    if (!run || tick) begin
      s_d.cnt = 16'h0000;
    end else begin
      s_d.cnt = s_q.cnt + DIV_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule
`default_nettype wire

// ---- src/scs_channel.sv ----
// SPI channel registers, shift engine and pin control
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Fine granularity ratio is divider code plus one plus sixteen times extension.
// - Transfers run only while the channel enable bit is set; resets disabled.
// - One transmit and one receive word, each split over low and high registers.
// - Receive and transmit DMA requests only when their configuration bits are set.
// - Direction field: 0 both ways, 1 receive only, 2 transmit only.
// - Word length is the bit-count field plus one, one to thirty-two bits.
// - Select is active high when polarity bit is 0, active low when 1.
// - Coarse granularity divides by two to the power of the divider code.
// - Clock idle level follows the clock level bit.
// - Sample on odd edges when sample-edge bit is 0, even edges when 1.
// - Step-select bit chooses power-of-two or one-cycle divider granularity.
// - Receive and transmit words go through the shared buffer when enabled.
// - Select setup delay of 1 to 4 serial clock cycles.
// - Optional start bit at programmed level precedes each word.
// - Slave-select detection field is stored only; no effect on this channel.
// - Manual select bit holds select active between words until cleared.
// - Turbo chains back-to-back words when transmit-only or receiving into the buffer, without releasing select or setup delay.
// - Receive from line 0 or line 1 by input select bit; resets to 1.
// - Line off bits gate transmit drive; reset drives line 0 only.
// - Status shows buffer receive full, receive empty, transmit full, transmit empty.
// - Done flag sets at transfer end and clears when shift register loads.
// - Status shows transmit register empty and receive register full.
module scs_channel
  import scs_pkg::*;
(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // Register port
  input  wire scs_bus_req_t  bus,
  output logic [15:0]        rd_data,
  // Serial pins
  output scs_pins_t          pins,
  input  wire logic          d0_i,
  input  wire logic          d1_i,
  // Shared buffer side
  input  wire scs_word_t     tx_buf_word,
  output logic               tx_buf_pop,
  output scs_word_t          rx_buf_push,
  input  wire scs_buf_stat_t buf_stat,
  // DMA requests
  output logic               dma_rx_req,
  output logic               dma_tx_req
);

  typedef struct packed {
    // Software-visible registers
    logic [7:0]  ext;
    logic        en;
    logic [15:0] tx_lo;
    logic [15:0] tx_hi;
    logic [15:0] rx_lo;
    logic [15:0] rx_hi;
    logic [15:0] cfg_lo;
    logic [15:0] cfg_hi;
    logic        done;
    logic        tx_empty;
    logic        rx_full;
    // Transfer engine
    scs_phase_t  phase;
    logic [32:0] sh_tx;
    logic [31:0] sh_rx;
    logic [6:0]  edge_n;
    logic [2:0]  wait_n;
    // Registered outputs
    scs_pins_t   pins;
    logic [15:0] rd_data;
    logic        dma_rx;
    logic        dma_tx;
    logic        tx_pop;
    scs_word_t   rx_push;
  } scs_state_t;

  scs_state_t s_q;
  scs_state_t s_d;

  // Decoded configuration
  logic [1:0]  dir;
  logic [4:0]  wl;
  logic        sel_pol;
  logic        idle_lvl;
  logic        clock_sample_edge;
  logic        rx_buf_on;
  logic        tx_buf_on;
  logic [1:0]  cs_setup_delay;
  logic        sb_on;
  logic        force_sel;
  logic        turbo;
  logic [6:0]  last_edge;
  logic        tick;
  logic        rx_bit;
  logic        word_ready;
  logic [15:0] stat_word;

  // Lower configuration half: direction, length, polarities
  assign dir       = s_q.cfg_lo[F_DIR_LSB +: 2];
  assign wl        = s_q.cfg_lo[F_WL_LSB +: 5];
  assign sel_pol   = s_q.cfg_lo[B_SEL_POL];
  assign idle_lvl  = s_q.cfg_lo[B_IDLE_LVL];
  assign clock_sample_edge       = s_q.cfg_lo[B_SAMPLE];

  // Upper configuration half: buffers, select timing, start bit, turbo
  assign rx_buf_on = s_q.cfg_hi[B_RXBUF];
  assign tx_buf_on = s_q.cfg_hi[B_TXBUF];
  assign cs_setup_delay       = s_q.cfg_hi[F_TCS_LSB +: 2];
  assign sb_on     = s_q.cfg_hi[B_SB_ON];
  assign force_sel = s_q.cfg_hi[B_FORCE];
  assign turbo     = s_q.cfg_hi[B_TURBO];

  // Status word; reserved top bits read zero
  assign stat_word = {9'h000, buf_stat.rx_full, buf_stat.rx_empty,
                      buf_stat.tx_full, buf_stat.tx_empty,
                      s_q.done, s_q.tx_empty, s_q.rx_full};

  // Edge count of a whole transfer: two per bit, start bit included
  assign last_edge = 7'({1'b0, wl} + 6'h01 + {5'h00, sb_on}) << 1;

  // Receive line choice
  assign rx_bit = s_q.cfg_hi[B_IN_SEL] ? d1_i : d0_i;

  // A word can start: receive-only needs room, otherwise a word to send
  // Receive-only keeps clocking while there is room, with nothing to send
  always_comb begin
    if (dir == DIR_RX) begin
      word_ready = rx_buf_on ? !buf_stat.rx_full : !s_q.rx_full;
    end else begin
      word_ready = tx_buf_on ? tx_buf_word.valid : !s_q.tx_empty;
    end
  end

  // Divider only counts while a transfer is under way
  // Settings change safely only while idle; a mid-word change bends one period
  scs_clk_div u_div (
    .clk      (clk),
    .rst_n    (rst_n),
    .run      (s_q.phase != ST_IDLE),
    .step_one (s_q.cfg_hi[B_STEP]),
    .code     (s_q.cfg_lo[F_CLOCK_DIVIDER_CODE_LSB +: 4]),
    .ext      (s_q.ext),
    .tick     (tick)
  );

  // Register port, engine and pin drive, all in one next-state pass
  always_comb begin
    logic        load;
    logic [31:0] word;
    logic [31:0] aligned;
    logic [31:0] rx_word;
    logic        sel_act;
    load    = 1'b0;
    word    = 32'h00000000;
    aligned = 32'h00000000;
    rx_word = 32'h00000000;
    sel_act = !sel_pol;
    s_d = s_q;
    s_d.tx_pop        = 1'b0;
    s_d.rx_push.valid = 1'b0;
    s_d.rd_data       = 16'h0000;

    // Register writes; slave-select detection bits are only stored
    // Reserved control bits are not stored and read back as zero
    if (bus.wr) begin
      case (bus.addr)
        OFS_CH1_CTRL: begin
          s_d.ext = bus.wdata[F_EXT_LSB +: 8];
          s_d.en  = bus.wdata[B_EN];
        end
        OFS_CH1_TXL: begin
          // Low half arms the word, so software writes the high half first
          s_d.tx_lo    = bus.wdata;
          s_d.tx_empty = 1'b0;
        end
        OFS_CH1_TXH:  s_d.tx_hi  = bus.wdata;
        OFS_CH2_CFGL: s_d.cfg_lo = bus.wdata;
        OFS_CH2_CFGH: s_d.cfg_hi = bus.wdata & CFGH_WMASK;
        default: ;
      endcase
    end

    // Register reads; unmapped addresses return zero
    // Read data stands one cycle only, zero otherwise
    if (bus.rd) begin
      case (bus.addr)
        OFS_CH1_CTRL: s_d.rd_data = {s_q.ext, 7'h00, s_q.en};
        OFS_CH1_TXL:  s_d.rd_data = s_q.tx_lo;
        OFS_CH1_TXH:  s_d.rd_data = s_q.tx_hi;
        OFS_CH1_RXL: begin
          // Low half releases the register; read the high half first
          s_d.rd_data = s_q.rx_lo;
          s_d.rx_full = 1'b0;
        end
        OFS_CH1_RXH:  s_d.rd_data = s_q.rx_hi;
        OFS_CH2_CFGL: s_d.rd_data = s_q.cfg_lo;
        OFS_CH2_CFGH: s_d.rd_data = s_q.cfg_hi;
        OFS_CH2_STAT: s_d.rd_data = stat_word;
        default: ;
      endcase
    end

    // Transfer sequence
    case (s_q.phase)
      ST_IDLE: begin
        s_d.pins.sclk = idle_lvl;
        s_d.pins.sel  = force_sel ? sel_act : !sel_act;
        // Select leads the first clock edge by the programmed setup time
        if (s_q.en && word_ready) begin
          load          = 1'b1;
          s_d.phase     = ST_SETUP;
          s_d.wait_n    = 3'({cs_setup_delay, 1'b0});
          s_d.pins.sel  = sel_act;
        end
      end
      ST_SETUP: begin
        // Each tick is half a serial cycle; 2*field+1 ticks here, first edge on the next, so 2*field+2 ticks of lead time
        if (tick) begin
          if (s_q.wait_n == 3'h0) begin
            s_d.phase = ST_SHIFT;
          end else begin
            s_d.wait_n = s_q.wait_n - 3'h1;
          end
        end
      end
      ST_SHIFT: begin
        if (tick) begin
          s_d.pins.sclk = !s_q.pins.sclk;
          // Receive bit is taken on the clock that launches the pin edge;
          // the far side has had half a serial period to settle it
          if (s_q.edge_n[0] != clock_sample_edge) begin
            s_d.sh_rx = {s_q.sh_rx[30:0], rx_bit};
          end else if (s_q.edge_n > 7'h01 && s_q.edge_n < last_edge) begin
            s_d.sh_tx = {s_q.sh_tx[31:0], 1'b0};
          end
          if (s_q.edge_n == last_edge) begin
            s_d.phase = ST_DONE;
          end else begin
            s_d.edge_n = s_q.edge_n + 7'h01;
          end
        end
      end
      ST_DONE: begin
        s_d.done = 1'b1;
        rx_word  = s_q.sh_rx & (WORD_ONES >> (WL_TOP - wl));
        // Runs after the read decode, so a new word beats a same-cycle read clear
        if (dir != DIR_TX) begin
          if (rx_buf_on) begin
            s_d.rx_push.valid = 1'b1;
            s_d.rx_push.data  = rx_word;
          end else begin
            s_d.rx_lo   = rx_word[15:0];
            s_d.rx_hi   = rx_word[31:16];
            s_d.rx_full = 1'b1;
          end
        end
        // Turbo keeps select asserted and skips the lead time between words
        // Only sources that never wait on software between words may chain
        if (turbo && s_q.en && word_ready && (dir == DIR_TX || rx_buf_on)) begin
          load      = 1'b1;
          s_d.phase = ST_SHIFT;
        end else begin
          s_d.phase    = ST_IDLE;
          s_d.pins.sel = force_sel ? sel_act : !sel_act;
        end
      end
      default: s_d.phase = ST_IDLE;
    endcase

    // Dropping the enable mid-word abandons it; clock and select go back to rest
    if (!s_q.en && (s_q.phase == ST_SETUP || s_q.phase == ST_SHIFT)) begin
      s_d.phase     = ST_IDLE;
      s_d.pins.sclk = idle_lvl;
      s_d.pins.sel  = force_sel ? sel_act : !sel_act;
    end

    // Shift register load consumes the transmit source
    // A low-half write in the load cycle is lost; software waits for the empty flag
    if (load) begin
      if (dir != DIR_RX) begin
        if (tx_buf_on) begin
          word       = tx_buf_word.data;
          s_d.tx_pop = 1'b1;
        end else begin
          word         = {s_q.tx_hi, s_q.tx_lo};
          s_d.tx_empty = 1'b1;
        end
      end
      aligned    = word << (WL_TOP - wl);
      s_d.sh_tx  = sb_on ? {s_q.cfg_hi[B_SB_LVL], aligned} : {aligned, 1'b0};
      s_d.sh_rx  = 32'h00000000;
      s_d.edge_n = 7'h01;
      s_d.done   = 1'b0;
    end

    // Data line drive only during a transfer and only where not switched off
    // Both lines carry the same bit; input select picks the line listened to
    s_d.pins.d0_o  = s_d.sh_tx[32];
    s_d.pins.d1_o  = s_d.sh_tx[32];
    s_d.pins.d0_oe = (s_d.phase != ST_IDLE) && (dir != DIR_RX)
                     && !s_q.cfg_hi[B_L0_OFF];
    s_d.pins.d1_oe = (s_d.phase != ST_IDLE) && (dir != DIR_RX)
                     && !s_q.cfg_hi[B_L1_OFF];

    // DMA requests follow the register and buffer levels
    // Levels, not pulses: they fall as soon as the condition clears
    s_d.dma_rx = s_q.cfg_lo[B_DMA_RX]
                 && (rx_buf_on ? !buf_stat.rx_empty : s_d.rx_full);
    s_d.dma_tx = s_q.cfg_lo[B_DMA_TX] && s_q.en
                 && (tx_buf_on ? !buf_stat.tx_full : s_d.tx_empty);
  end

  // Single state register; transmit register reads empty after reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q          <= '0;
      s_q.ext      <= RST_EXT;
      s_q.tx_lo    <= RST_WORD;
      s_q.tx_hi    <= RST_WORD;
      s_q.rx_lo    <= RST_WORD;
      s_q.rx_hi    <= RST_WORD;
      s_q.cfg_lo   <= RST_CFGL;
      s_q.cfg_hi   <= RST_CFGH;
      s_q.tx_empty <= 1'b1;
      s_q.phase    <= ST_IDLE;
      // Select stays zero from the clear above: inactive for the reset polarity
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign rd_data     = s_q.rd_data;
  assign pins        = s_q.pins;
  assign tx_buf_pop  = s_q.tx_pop;
  assign rx_buf_push = s_q.rx_push;
  assign dma_rx_req  = s_q.dma_rx;
  assign dma_tx_req  = s_q.dma_tx;

endmodule
`default_nettype wire

// ---- sim/scs_channel_monitor.sv ----
// Port-level checks for the SPI channel block
`timescale 1ns/1ps
`default_nettype none
module scs_channel_monitor
  import scs_pkg::*;
(
  // Clock and reset
  input wire logic          clk,
  input wire logic          rst_n,
  // Register port
  input wire scs_bus_req_t  bus,
  input wire logic [15:0]   rd_data,
  // Pins, buffer and requests
  input wire scs_pins_t     pins,
  input wire scs_buf_stat_t buf_stat,
  input wire scs_word_t     rx_buf_push,
  input wire logic          tx_buf_pop,
  input wire logic          dma_rx_req,
  input wire logic          dma_tx_req
);
  logic [15:0] ctl_q;
  logic [15:0] cfl_q;
  logic [15:0] cfh_q;
  logic [1:0]  age_q;
  logic        wcfg;
  logic        settled;
  logic        inact;

  // Shadow settings; age waits out the register and pin pipeline
  assign wcfg = bus.wr && (bus.addr inside {OFS_CH1_CTRL, OFS_CH2_CFGL, OFS_CH2_CFGH});
  assign settled = age_q == 2'h3;
  assign inact = pins.sel == cfl_q[B_SEL_POL];
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctl_q <= RST_CFGL;
      cfl_q <= RST_CFGL;
      cfh_q <= RST_CFGH;
      age_q <= 2'h0;
    end else begin
      if (bus.wr && bus.addr == OFS_CH1_CTRL) ctl_q <= bus.wdata;
      if (bus.wr && bus.addr == OFS_CH2_CFGL) cfl_q <= bus.wdata;
      if (bus.wr && bus.addr == OFS_CH2_CFGH) cfh_q <= bus.wdata;
      age_q <= wcfg ? 2'h0 : (settled ? age_q : age_q + 2'h1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_rd_idle; !$past(bus.rd) |-> rd_data == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its slot");
  property p_stat;
    $past(bus.rd) && $past(bus.addr) == OFS_CH2_STAT
      |-> rd_data[15:7] == 9'h000 && rd_data[6:3] == $past(buf_stat);
  endproperty
  a_stat: assert property (p_stat) else $error("status buffer flags wrong");
  property p_sel_en; settled && !ctl_q[B_EN] && !cfh_q[B_FORCE] |-> inact; endproperty
  a_sel_en: assert property (p_sel_en) else $error("select active while disabled");
  property p_force; settled && cfh_q[B_FORCE] |-> pins.sel == !cfl_q[B_SEL_POL]; endproperty
  a_force: assert property (p_force) else $error("manual select not active");
  property p_dma_rx; settled && !cfl_q[B_DMA_RX] |-> !dma_rx_req; endproperty
  a_dma_rx: assert property (p_dma_rx) else $error("rx request while off");
  property p_dma_tx; settled && !cfl_q[B_DMA_TX] |-> !dma_tx_req; endproperty
  a_dma_tx: assert property (p_dma_tx) else $error("tx request while off");
  property p_idle_clk;
    settled && inact && $past(inact) |-> pins.sclk == cfl_q[B_IDLE_LVL];
  endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("serial clock not idle");
  property p_oe;
    settled |-> !(pins.d1_oe && cfh_q[B_L1_OFF]) && !(pins.d0_oe && cfh_q[B_L0_OFF]);
  endproperty
  a_oe: assert property (p_oe) else $error("data line driven while off");
  property p_buf;
    settled |-> !(rx_buf_push.valid && !cfh_q[B_RXBUF]) && !(tx_buf_pop && !cfh_q[B_TXBUF]);
  endproperty
  a_buf: assert property (p_buf) else $error("buffer used while off");
endmodule

bind scs_channel scs_channel_monitor scs_channel_monitor_i (
  .clk(clk), .rst_n(rst_n), .bus(bus), .rd_data(rd_data), .pins(pins),
  .buf_stat(buf_stat), .rx_buf_push(rx_buf_push), .tx_buf_pop(tx_buf_pop),
  .dma_rx_req(dma_rx_req), .dma_tx_req(dma_tx_req));
`default_nettype wire

// ---- sim/scs_spi_peer.sv ----
// Behavioural SPI peripheral on the far side of the channel
`timescale 1ns/1ps
`default_nettype none
module scs_spi_peer (
  // Serial pins
  input  wire logic        sclk,
  input  wire logic        sel,
  input  wire logic        d_in,
  output logic             d_out,
  // Test control
  input  wire logic        sel_act,
  input  wire logic [31:0] word_out,
  input  wire logic [5:0]  nbits,
  output logic [31:0]      word_in
);
  int idx;

  initial begin
    d_out = 1'b0;
    word_in = 32'h0;
    idx = 0;
  end
  // Load on select; on release flip the line so stale data never looks valid
  always @(sel) begin
    if (sel === sel_act) begin
      idx = nbits - 1;
      word_in = 32'h0;
      d_out = word_out[idx];
    end else begin
      d_out = ~d_out;
    end
  end
  // Idle-low clock: capture on odd (rising) edges, change on even ones
  always @(posedge sclk) if (sel === sel_act) word_in = {word_in[30:0], d_in};
  always @(negedge sclk) begin
    if (sel === sel_act && idx > 0) begin
      idx--;
      d_out = word_out[idx];
    end
  end
endmodule
`default_nettype wire

// ---- sim/tb_scs_channel.sv ----
// Self-checking bench for the SPI channel block
`timescale 1ns/1ps
`default_nettype none
module tb_scs_channel;
  import scs_pkg::*;
  logic         clk;
  logic         rst_n;
  scs_bus_req_t bus;
  logic [15:0]  rd_data;
  scs_pins_t    pins;
  logic         dma_rx_request_on;
  logic         dma_tx_request_on;
  logic         sel_act;
  logic         p_out;
  logic [31:0]  p_word;
  logic [31:0]  p_got;
  logic [5:0]   p_bits;
  logic [15:0]  v;
  int           n_fail;
  int           total_checks;
  realtime      t_last;
  realtime      per;
  wire logic    d0_lvl = pins.d0_oe ? pins.d0_o : clk;
  wire logic    d1_lvl = pins.d1_oe ? pins.d1_o : p_out;

  // Buffer side held quiet: this channel is used in register mode only
  scs_channel scs_channel_i (.clk(clk), .rst_n(rst_n), .bus(bus), .rd_data(rd_data),
    .pins(pins), .d0_i(d0_lvl), .d1_i(d1_lvl), .tx_buf_word(33'h0), .tx_buf_pop(),
    .rx_buf_push(), .buf_stat(4'hA), .dma_rx_req(dma_rx_request_on), .dma_tx_req(dma_tx_request_on));
  scs_spi_peer scs_spi_peer_i (.sclk(pins.sclk), .sel(pins.sel), .d_in(d0_lvl),
    .d_out(p_out), .sel_act(sel_act), .word_out(p_word), .nbits(p_bits), .word_in(p_got));

  always #5 clk = ~clk;
  // Serial clock period, last one measured wins
  always @(posedge pins.sclk) begin
    per = $realtime - t_last;
    t_last = $realtime;
  end

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk);
    bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 d = rd_data;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    chk({16'h0000, d}, {16'h0000, exp});
  endtask
  // Poll until a word has been received, bounded
  task automatic wait_rx();
    int i;
    v = 16'h0000;
    for (i = 0; i < 600 && v[0] !== 1'b1; i++) rd(OFS_CH2_STAT, v);
    chk({31'h0, v[0]}, 32'h1);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #200us;
    n_fail++;
    print_verdict();
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    bus = '0;
    sel_act = 1'b1;
    p_word = 32'h0;
    p_bits = 6'h08;
    n_fail = 0;
    total_checks = 0;
    t_last = 0;
    per = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values, access kinds, unmapped place
    rchk(OFS_CH1_CTRL, 16'h0000);
    rchk(OFS_CH2_CFGH, 16'h0006);
    rchk(OFS_CH2_STAT, 16'h0052);
    wr(OFS_CH1_CTRL, 16'hFFFE);
    rchk(OFS_CH1_CTRL, 16'hFF00);
    wr(OFS_CH2_CFGH, 16'hFFFF);
    rchk(OFS_CH2_CFGH, 16'h3FFF);
    wr(OFS_CH1_RXL, 16'h1234);
    rchk(OFS_CH1_RXL, 16'h0000);
    wr(OFS_CH1_TXH, 16'h1234);
    rchk(OFS_CH1_TXH, 16'h1234);
    wr(16'h3556, 16'hFFFF);
    rchk(16'h3556, 16'h0000);
    wr(OFS_CH2_CFGH, 16'h0016);
    repeat (3) @(posedge clk);
    chk(pins.sel, 32'h1);
    wr(OFS_CH2_CFGH, 16'h0006);
    repeat (3) @(posedge clk);
    chk(pins.sel, 32'h0);
    $display("test registers done");
    // 8-bit word, coarse divide by 2, held back until enabled
    wr(OFS_CH2_CFGL, 16'h0384);
    p_word = 32'h3C;
    wr(OFS_CH1_TXH, 16'h0000);
    wr(OFS_CH1_TXL, 16'h00A5);
    repeat (50) @(posedge clk);
    chk(pins.sel, 32'h0);
    wr(OFS_CH1_CTRL, 16'h0001);
    wait_rx();
    chk(int'(per), 32'h28);
    chk(p_got, 32'hA5);
    rchk(OFS_CH1_RXH, 16'h0000);
    rchk(OFS_CH1_RXL, 16'h003C);
    rchk(OFS_CH2_STAT, 16'h0056);
    $display("test short word done");
    // 20-bit word, select active low, fine divider with extension 1
    wr(OFS_CH1_CTRL, 16'h0000);
    sel_act = 1'b0;
    p_word = 32'h54321;
    p_bits = 6'h14;
    wr(OFS_CH2_CFGL, 16'hC9C8);
    wr(OFS_CH2_CFGH, 16'h2006);
    wr(OFS_CH1_TXH, 16'h000A);
    wr(OFS_CH1_TXL, 16'hBCDE);
    wr(OFS_CH1_CTRL, 16'h0101);
    wait_rx();
    chk(int'(per), 32'h17C);
    chk(p_got, 32'hABCDE);
    chk({dma_rx_request_on, dma_tx_request_on}, 32'h3);
    rchk(OFS_CH1_RXH, 16'h0005);
    rchk(OFS_CH1_RXL, 16'h4321);
    $display("test long word done");
    // Request enables, both states
    repeat (3) @(posedge clk);
    chk({dma_rx_request_on, dma_tx_request_on}, 32'h1);
    wr(OFS_CH2_CFGL, 16'h09C8);
    repeat (3) @(posedge clk);
    chk({dma_rx_request_on, dma_tx_request_on}, 32'h0);
    $display("test requests done");
    // 8-bit word led by a start bit at level 1, select lead time field 1
    wr(OFS_CH1_CTRL, 16'h0000);
    sel_act = 1'b1;
    p_word = 32'h0C3;
    p_bits = 6'h09;
    wr(OFS_CH2_CFGL, 16'h0384);
    wr(OFS_CH2_CFGH, 16'h0386);
    wr(OFS_CH1_TXH, 16'h0000);
    wr(OFS_CH1_TXL, 16'h005A);
    wr(OFS_CH1_CTRL, 16'h0001);
    wait_rx();
    chk(p_got, 32'h15A);
    rchk(OFS_CH1_RXL, 16'h00C3);
    $display("test start bit done");
    print_verdict();
  end
endmodule
`default_nettype wire
